//--- shared/ldc_defines.svh
// Offsets, field positions, reset values and bus constants of the Led_enable_high bank
`ifndef LDC_DEFINES_SVH
`define LDC_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define LDC_OFS_MODE_CONFIG 8'h00
`define LDC_OFS_LED_ENABLE_HIGH 8'h01
`define LDC_OFS_LED_ENABLE_LOW 8'h02
`define LDC_OFS_CURRENT_GAIN_SETUP 8'h03
`define LDC_OFS_CHANNEL_FUNCTION_SELECT 8'h04
`define LDC_OFS_PORT_DIRECTION 8'h05
`define LDC_OFS_PORT_OUTPUT_LEVEL 8'h06
`define LDC_OFS_PORT_IRQ_MASK 8'h07
`define LDC_OFS_PORT_INPUT_STATE 8'h08
`define LDC_OFS_SAMPLE_RATE_SETUP 8'h09
`define LDC_OFS_DUTY_FIRST 8'h10
`define LDC_OFS_DUTY_LAST 8'h1f
`define LDC_OFS_FRAME_FIRST 8'h20
`define LDC_OFS_FRAME_LAST 8'haf
`define LDC_OFS_DUTY_LOAD_TRIGGER 8'hb0
`define LDC_OFS_FRAME_INTERVAL 8'hb6
`define LDC_OFS_FIRST_FRAME_SELECT 8'hb7

// ****************************************
// Reset values and field positions
// ****************************************
`define LDC_RST_MODE_CONFIG 8'h80
`define LDC_RST_LED_ENABLE 8'hff
`define LDC_RST_ZERO 8'h00
`define LDC_MODE_USED_MASK 8'hf0
`define LDC_BIT_SOFT_SHUTDOWN 7
`define LDC_BIT_AUDIO_MOD 4
`define LDC_BIT_CASCADE_ROLE 7
`define LDC_BIT_AUTO_GAIN_OFF 3
`define LDC_DUTY_COUNT 16
`define LDC_FRAME_BYTES 144

// ****************************************
// Serial bus constants
// ****************************************
`define LDC_BUS_ADDR_FIXED 5'h1d

`endif

//--- shared/ldc_pkg.sv
// Types shared by the Led_enable_high bank
package ldc_pkg;

	typedef enum logic [1:0] {
		LDC_MODE_PWM_DIRECT,
		LDC_MODE_AUTO_FRAMES,
		LDC_MODE_AUDIO_FRAMES,
		LDC_MODE_UNAVAILABLE
	} ldc_play_mode_t;

	typedef enum logic [2:0] {
		LDC_ST_IDLE,
		LDC_ST_DEVICE,
		LDC_ST_POINTER,
		LDC_ST_WRITE,
		LDC_ST_READ
	} ldc_bus_state_t;

	typedef struct packed {
		logic soft_shutdown_bit;
		ldc_play_mode_t play_mode;
		logic audio_modulation_bit;
		logic [15:0] channel_enable;
		logic cascade_role_bit;
		logic [2:0] current_scale;
		logic auto_gain_off_bit;
		logic [2:0] audio_gain_field;
		logic [7:0] channel_function;
		logic [7:0] sample_rate;
		logic [7:0] frame_interval;
		logic [7:0] first_frame;
	} ldc_ctrl_t;

	typedef struct packed {
		logic [7:0] out_level;
		logic [7:0] out_enable;
	} ldc_port_drive_t;

endpackage

//--- hdl/ldc_regs.sv
// LED driver control register bank with its two-wire serial slave
// Operation
// [RULE1] Only the pin state register reads back
// [RULE2] Shutdown bit seven, resets set
// [RULE3] Mode bits six:five pick playback source
// [RULE4] Bit four selects audio current modulation
// [RULE5] Two enable registers, reset all on
// [RULE6] Cascade, scaling, gain control, gain; reset zero
// [RULE7] Scaling codes select current multiplier
// [RULE8] Gain control off bit; gain 3dB steps
// [RULE9] Function bit makes upper channel a port
// [RULE10] Direction bit: zero output, one input
// [RULE11] Output level bit drives port pin
// [RULE12] Mask bit zero enables port interrupt
// [RULE13] Sixteen duty registers at consecutive addresses
// [RULE14] Load trigger copies pending duties to active
// [RULE15] Frame store holds eight animation frames
// [RULE16] Frame interval register sets playback delay
// [RULE17] Start frame register, resets zero
// [RULE18] Sample rate register, resets zero
// [RULE19] Bus address is 11101 plus strap
// [RULE20] Pointer increments after each acknowledged byte
// [RULE21] Master reads after pointer write, restart
// [RULE22] Enabled input change holds interrupt till read
// [RULE23] Unused mode bits ignored, bad code harmless
`timescale 1ns/1ps
`include "ldc_defines.svh"

module ldc_regs #(
	parameter int DUTY_COUNT = `LDC_DUTY_COUNT,
	parameter int FRAME_BYTES = `LDC_FRAME_BYTES
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe,
	input wire logic [1:0] i_addr_strap,
	input wire logic [7:0] i_port_pins,
	output ldc_pkg::ldc_port_drive_t o_port_drive,
	output logic o_irq_n_pin,
	output logic o_irq_n_pin_oe,
	output ldc_pkg::ldc_ctrl_t o_ctrl,
	output logic [7:0] o_duty_active [DUTY_COUNT],
	input wire logic [7:0] i_frame_index,
	output logic [7:0] o_frame_data
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [2:0] scl_sync;
	logic [2:0] sda_sync;
	logic [7:0] port_s1;
	logic [7:0] port_s2;
	logic [7:0] port_s3;
	logic [1:0] strap_s1;
	logic [1:0] strap_s2;
	logic [1:0] strap_s3;
	logic scl_q;
	logic sda_q;
	logic [7:0] port_q;
	logic [1:0] strap;
	logic next_scl;
	logic next_sda;
	logic [7:0] next_port;
	logic [1:0] next_strap;

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
			port_s1 <= 8'h00;
			port_s2 <= 8'h00;
			port_s3 <= 8'h00;
			strap_s1 <= 2'h0;
			strap_s2 <= 2'h0;
			strap_s3 <= 2'h0;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			port_q <= 8'h00;
			strap <= 2'h0;
		end else begin
			scl_sync <= {scl_sync[1:0], i_scl};
			sda_sync <= {sda_sync[1:0], i_sda};
			port_s1 <= i_port_pins;
			port_s2 <= port_s1;
			port_s3 <= port_s2;
			strap_s1 <= i_addr_strap;
			strap_s2 <= strap_s1;
			strap_s3 <= strap_s2;
			scl_q <= next_scl;
			sda_q <= next_sda;
			port_q <= next_port;
			strap <= next_strap;
		end
	end

	// A level counts only once the second and third stages agree
	always_comb begin
		next_scl = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_q;
		next_sda = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_q;
		next_strap = (strap_s2 == strap_s3) ? strap_s3 : strap;
		for (int i = 0; i < 8; i++) begin
			next_port[i] = (port_s2[i] == port_s3[i]) ? port_s3[i] : port_q[i];
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	assign scl_rise = next_scl & ~scl_q;
	assign scl_fall = ~next_scl & scl_q;
	assign bus_start = scl_q & next_scl & sda_q & ~next_sda;
	assign bus_stop = scl_q & next_scl & ~sda_q & next_sda;

	// ****************************************
	// Serial slave
	// ****************************************
	ldc_pkg::ldc_bus_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic [7:0] tx;
	logic [7:0] pointer;
	logic read_dir;
	logic master_nack;
	logic wr_stb;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic state_read;

	function automatic logic [7:0] read_value(input logic [7:0] addr, input logic [7:0] pins);
		read_value = (addr == `LDC_OFS_PORT_INPUT_STATE) ? pins : 8'h00;
	endfunction

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			state <= ldc_pkg::LDC_ST_IDLE;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			tx <= 8'h00;
			pointer <= 8'h00;
			read_dir <= 1'b0;
			master_nack <= 1'b0;
			o_sda_oe <= 1'b0;
			wr_stb <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 8'h00;
			state_read <= 1'b0;
		end else begin
			wr_stb <= 1'b0;
			state_read <= 1'b0;
			if (bus_start) begin
				state <= ldc_pkg::LDC_ST_DEVICE;
				bit_cnt <= 4'h0;
				o_sda_oe <= 1'b0;
			end else if (bus_stop) begin
				state <= ldc_pkg::LDC_ST_IDLE;
				o_sda_oe <= 1'b0;
			end else if (state != ldc_pkg::LDC_ST_IDLE && scl_rise) begin
				if (bit_cnt < 4'h8) begin
					shift <= {shift[6:0], next_sda};
				end else if (state == ldc_pkg::LDC_ST_READ) begin
					master_nack <= next_sda;
				end
				bit_cnt <= bit_cnt + 4'h1;
			end else if (state != ldc_pkg::LDC_ST_IDLE && scl_fall) begin
				if (bit_cnt == 4'h8) begin
					unique case (state)
						ldc_pkg::LDC_ST_DEVICE: begin
							if (shift[7:1] == {`LDC_BUS_ADDR_FIXED, strap}) begin // RULE19
								o_sda_oe <= 1'b1;
								read_dir <= shift[0];
							end else begin
								state <= ldc_pkg::LDC_ST_IDLE;
							end
						end
						ldc_pkg::LDC_ST_POINTER: begin
							pointer <= shift;
							o_sda_oe <= 1'b1;
						end
						ldc_pkg::LDC_ST_WRITE: begin
							wr_stb <= 1'b1;
							wr_addr <= pointer;
							wr_data <= shift;
							pointer <= pointer + 8'h01; // RULE20
							o_sda_oe <= 1'b1;
						end
						default: begin
							o_sda_oe <= 1'b0;
						end
					endcase
				end else if (bit_cnt == 4'h9) begin
					bit_cnt <= 4'h0;
					o_sda_oe <= 1'b0;
					if (state == ldc_pkg::LDC_ST_POINTER) begin
						state <= ldc_pkg::LDC_ST_WRITE;
					end else if (state == ldc_pkg::LDC_ST_DEVICE && !read_dir) begin
						state <= ldc_pkg::LDC_ST_POINTER;
					end else if (state == ldc_pkg::LDC_ST_READ && master_nack) begin
						state <= ldc_pkg::LDC_ST_IDLE;
					end else if (state != ldc_pkg::LDC_ST_WRITE) begin
						// Read follows a pointer write and a restart
						state <= ldc_pkg::LDC_ST_READ; // RULE21
						tx <= read_value(pointer, port_q); // RULE1
						o_sda_oe <= ~((pointer == `LDC_OFS_PORT_INPUT_STATE) & port_q[7]);
						state_read <= (pointer == `LDC_OFS_PORT_INPUT_STATE);
						pointer <= pointer + 8'h01;
					end
				end else if (state == ldc_pkg::LDC_ST_READ) begin
					o_sda_oe <= ~tx[3'(7 - bit_cnt)];
				end
			end
		end
	end

	// Open drain: only ever pulls low
	assign o_sda = 1'b0;

	// ****************************************
	// Control registers
	// ****************************************
	logic [7:0] mode_config;
	logic [7:0] led_enable_high;
	logic [7:0] led_enable_low;
	logic [7:0] current_gain_setup;
	logic [7:0] channel_function_select;
	logic [7:0] port_direction;
	logic [7:0] port_output_level;
	logic [7:0] port_irq_mask;
	logic [7:0] sample_rate_setup;
	logic [7:0] frame_interval;
	logic [7:0] first_frame_select;

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			mode_config <= `LDC_RST_MODE_CONFIG; // RULE2
			led_enable_high <= `LDC_RST_LED_ENABLE; // RULE5
			led_enable_low <= `LDC_RST_LED_ENABLE;
			current_gain_setup <= `LDC_RST_ZERO; // RULE6
			channel_function_select <= `LDC_RST_ZERO;
			port_direction <= `LDC_RST_ZERO; // RULE10
			port_output_level <= `LDC_RST_ZERO; // RULE11
			port_irq_mask <= `LDC_RST_ZERO; // RULE12
			sample_rate_setup <= `LDC_RST_ZERO; // RULE18
			frame_interval <= `LDC_RST_ZERO;
			first_frame_select <= `LDC_RST_ZERO; // RULE17
		end else if (wr_stb) begin
			unique case (wr_addr)
				// Low mode bits are not kept; code 11 is stored as written
				`LDC_OFS_MODE_CONFIG: mode_config <= wr_data & `LDC_MODE_USED_MASK; // RULE23
				`LDC_OFS_LED_ENABLE_HIGH: led_enable_high <= wr_data;
				`LDC_OFS_LED_ENABLE_LOW: led_enable_low <= wr_data;
				`LDC_OFS_CURRENT_GAIN_SETUP: current_gain_setup <= wr_data;
				`LDC_OFS_CHANNEL_FUNCTION_SELECT: channel_function_select <= wr_data;
				`LDC_OFS_PORT_DIRECTION: port_direction <= wr_data;
				`LDC_OFS_PORT_OUTPUT_LEVEL: port_output_level <= wr_data;
				`LDC_OFS_PORT_IRQ_MASK: port_irq_mask <= wr_data;
				`LDC_OFS_SAMPLE_RATE_SETUP: sample_rate_setup <= wr_data;
				`LDC_OFS_FRAME_INTERVAL: frame_interval <= wr_data; // RULE16
				`LDC_OFS_FIRST_FRAME_SELECT: first_frame_select <= wr_data;
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		o_ctrl.soft_shutdown_bit = mode_config[`LDC_BIT_SOFT_SHUTDOWN]; // RULE2
		o_ctrl.play_mode = ldc_pkg::ldc_play_mode_t'(mode_config[6:5]); // RULE3
		o_ctrl.audio_modulation_bit = mode_config[`LDC_BIT_AUDIO_MOD]; // RULE4
		o_ctrl.channel_enable = {led_enable_high, led_enable_low}; // RULE5
		o_ctrl.cascade_role_bit = current_gain_setup[`LDC_BIT_CASCADE_ROLE]; // RULE6
		// Multiplier decode lives in the analog current DAC
		o_ctrl.current_scale = current_gain_setup[6:4]; // RULE7
		o_ctrl.auto_gain_off_bit = current_gain_setup[`LDC_BIT_AUTO_GAIN_OFF]; // RULE8
		o_ctrl.audio_gain_field = current_gain_setup[2:0];
		o_ctrl.channel_function = channel_function_select; // RULE9
		o_ctrl.sample_rate = sample_rate_setup;
		o_ctrl.frame_interval = frame_interval;
		o_ctrl.first_frame = first_frame_select;
	end

	// Port pins bypass current scaling, driven only as outputs
	assign o_port_drive.out_level = port_output_level; // RULE11
	assign o_port_drive.out_enable = channel_function_select & ~port_direction; // RULE9 RULE10

	// ****************************************
	// Duty storage with load trigger
	// ****************************************
	logic [7:0] duty_pending [DUTY_COUNT];
	logic duty_load;

	assign duty_load = wr_stb && (wr_addr == `LDC_OFS_DUTY_LOAD_TRIGGER); // RULE14

	genvar g;
	generate
		for (g = 0; g < DUTY_COUNT; g++) begin : g_duty
			always_ff @(posedge i_clk) begin
				if (!i_resetn) begin
					duty_pending[g] <= 8'h00;
				end else if (wr_stb && wr_addr == 8'(`LDC_OFS_DUTY_FIRST + g)) begin
					duty_pending[g] <= wr_data; // RULE13
				end
			end

			always_ff @(posedge i_clk) begin
				if (!i_resetn) begin
					o_duty_active[g] <= 8'h00;
				end else if (duty_load) begin
					o_duty_active[g] <= duty_pending[g]; // RULE14
				end
			end
		end
	endgenerate

	// ****************************************
	// Frame store
	// ****************************************
	logic [7:0] frame_mem [FRAME_BYTES];
	logic frame_hit;

	assign frame_hit = wr_stb && wr_addr >= `LDC_OFS_FRAME_FIRST && wr_addr <= `LDC_OFS_FRAME_LAST;

	// No reset: a large store costs too much reset routing
	always_ff @(posedge i_clk) begin
		if (frame_hit) begin
			frame_mem[wr_addr - `LDC_OFS_FRAME_FIRST] <= wr_data; // RULE15
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_frame_data <= 8'h00;
		end else if (i_frame_index < 8'(FRAME_BYTES)) begin
			o_frame_data <= frame_mem[i_frame_index];
		end else begin
			o_frame_data <= 8'h00;
		end
	end

	// ****************************************
	// Port input interrupt
	// ****************************************
	logic irq;
	logic irq_event;

	assign irq_event = |((port_q ^ next_port) & channel_function_select & port_direction & ~port_irq_mask); // RULE22

	// A change in the same cycle as the clearing read wins
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			irq <= 1'b0;
		end else if (irq_event) begin
			irq <= 1'b1; // RULE22
		end else if (state_read) begin
			irq <= 1'b0;
		end
	end

	assign o_irq_n_pin = 1'b0;
	assign o_irq_n_pin_oe = irq;

	// ****************************************
	// Checks
	// ****************************************
	AST_SHUTDOWN_RESET: assert property (@(posedge i_clk) $rose(i_resetn) |-> o_ctrl.soft_shutdown_bit) // RULE2
		else $error("Shutdown bit not set after reset");
	AST_ENABLE_RESET: assert property (@(posedge i_clk) $rose(i_resetn) |-> o_ctrl.channel_enable == 16'hffff) // RULE5
		else $error("Channel enables not all on after reset");
	AST_MODE_LOW_ZERO: assert property (@(posedge i_clk) disable iff (!i_resetn) mode_config[3:0] == 4'h0) // RULE23
		else $error("Unused mode bits stored");
	AST_PTR_INC: assert property (@(posedge i_clk) disable iff (!i_resetn)
		wr_stb |-> pointer == 8'(wr_addr + 8'h01)) // RULE20
		else $error("Pointer did not advance after write");
	AST_DUTY_LOAD: assert property (@(posedge i_clk) disable iff (!i_resetn)
		duty_load |=> o_duty_active[0] == $past(duty_pending[0])) // RULE14
		else $error("Duty load did not copy pending value");
	AST_DUTY_HOLD: assert property (@(posedge i_clk) disable iff (!i_resetn)
		!duty_load |=> $stable(o_duty_active[0])) // RULE14
		else $error("Active duty changed without load");
	AST_IRQ_SET: assert property (@(posedge i_clk) disable iff (!i_resetn) irq_event |=> o_irq_n_pin_oe) // RULE22
		else $error("Interrupt not raised on enabled input change");
	AST_IRQ_CLEAR: assert property (@(posedge i_clk) disable iff (!i_resetn)
		state_read && !irq_event |=> !o_irq_n_pin_oe) // RULE22
		else $error("Interrupt not cleared by state read");
	AST_PORT_OE: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(port_direction[0] || !channel_function_select[0]) |-> !o_port_drive.out_enable[0]) // RULE10
		else $error("Port driven while input or LED");
	AST_ADDR_ACK: assert property (@(posedge i_clk) disable iff (!i_resetn)
		state == ldc_pkg::LDC_ST_DEVICE && scl_fall && bit_cnt == 4'h8 && !bus_start && !bus_stop
		&& shift[7:1] != {`LDC_BUS_ADDR_FIXED, strap} |=> !o_sda_oe && state == ldc_pkg::LDC_ST_IDLE) // RULE19
		else $error("Foreign address acknowledged");

endmodule

//--- test/ldc_bus_master.sv
// Two-wire bus master model that drives the register bank from the far side
`timescale 1ns/1ps

module ldc_bus_master #(
	parameter int HALF = 6
) (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_low
);
	// ****************************************
	// Line levels
	// ****************************************
	// Released lines float high through the pull-up, so idle is both high
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	// Data moves only while the clock is low; sampled just before the clock falls
	task automatic put_bit(input logic b, output logic got);
		tick(2);
		o_sda_low <= ~b;
		tick(HALF);
		o_scl <= 1'b1;
		tick(HALF);
		got = i_sda;
		o_scl <= 1'b0;
	endtask

	// ****************************************
	// Conditions and bytes
	// ****************************************
	// Also serves as repeated start, since it begins from a low clock
	task automatic start_cond();
		tick(2);
		o_sda_low <= 1'b0;
		tick(HALF);
		o_scl <= 1'b1;
		tick(HALF);
		o_sda_low <= 1'b1;
		tick(HALF);
		o_scl <= 1'b0;
	endtask

	task automatic stop_cond();
		tick(2);
		o_sda_low <= 1'b1;
		tick(HALF);
		o_scl <= 1'b1;
		tick(HALF);
		o_sda_low <= 1'b0;
		tick(HALF);
	endtask

	task automatic byte_out(input logic [7:0] b, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			put_bit(b[i], g);
		end
		put_bit(1'b1, g);
		ack = (g === 1'b0);
	endtask

	task automatic byte_in(input logic last, output logic [7:0] b);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			put_bit(1'b1, g);
			b[i] = g;
		end
		put_bit(last, g);
	endtask

	// ****************************************
	// Transfers
	// ****************************************
	task automatic write_regs(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] data [$],
		output logic ack);
		logic a;
		start_cond();
		byte_out({dev, 1'b0}, ack);
		if (ack) begin
			byte_out(ptr, a);
			ack = ack & a;
			foreach (data[k]) begin
				byte_out(data[k], a);
				ack = ack & a;
			end
		end
		stop_cond();
	endtask

	// Pointer write, repeated start, then one byte ended by a refusal
	task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] val);
		logic a;
		start_cond();
		byte_out({dev, 1'b0}, a);
		byte_out(ptr, a);
		start_cond();
		byte_out({dev, 1'b1}, a);
		byte_in(1'b1, val);
		stop_cond();
	endtask
endmodule

//--- test/tb_ldc_regs.sv
// Self-checking bench of the Led_enable_high bank
`timescale 1ns/1ps
`include "ldc_defines.svh"

module tb_ldc_regs;
	logic i_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic [1:0] strap = 2'h0;
	logic [7:0] pins = 8'h00;
	logic [7:0] frame_idx = 8'h00;
	logic scl;
	logic m_sda_low;
	logic sda_val;
	logic sda_oe;
	logic irq_val;
	logic irq_oe;
	ldc_pkg::ldc_port_drive_t port_drive;
	ldc_pkg::ldc_ctrl_t ctrl;
	logic [7:0] duty_act [16];
	logic [7:0] frame_data;
	int n_errors = 0;
	int n_compared = 0;
	logic [6:0] dev;
	logic ack;
	logic [7:0] q [$];
	// Open-drain lines with pull-ups: low only while some party pulls
	wire logic sda_line = ~(m_sda_low | (sda_oe & ~sda_val));
	wire logic irq_line = ~(irq_oe & ~irq_val);

	always #2 i_clk = ~i_clk;

	ldc_regs u_ldc_regs (.i_clk(i_clk), .i_resetn(i_resetn), .i_scl(scl), .i_sda(sda_line), .o_sda(sda_val),
		.o_sda_oe(sda_oe), .i_addr_strap(strap), .i_port_pins(pins), .o_port_drive(port_drive),
		.o_irq_n_pin(irq_val), .o_irq_n_pin_oe(irq_oe), .o_ctrl(ctrl), .o_duty_active(duty_act),
		.i_frame_index(frame_idx), .o_frame_data(frame_data));

	ldc_bus_master u_ldc_bus_master (.i_clk(i_clk), .i_sda(sda_line), .o_scl(scl), .o_sda_low(m_sda_low));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		if (n_errors == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] ptr);
		u_ldc_bus_master.write_regs(dev, ptr, q, ack);
		check(ack, 1'b1);
	endtask

	function automatic logic [7:0] exp_mode(input logic [7:0] v);
		return {v[7:4], 4'h0};
	endfunction

	function automatic logic [7:0] exp_oe(input logic [7:0] func, input logic [7:0] dir);
		return func & ~dir;
	endfunction

	// Writing 146 bytes dominates; this span leaves a wide margin
	initial begin
		repeat (90000) @(posedge i_clk);
		n_errors++;
		wrap_up();
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		logic [7:0] v;
		logic [7:0] r;
		logic [7:0] regs [8];
		logic [7:0] duty [16];
		logic [7:0] frm [145];
		void'($urandom(32'h6c1e));
		v = 8'($urandom);
		strap <= v[1:0];
		dev = {`LDC_BUS_ADDR_FIXED, v[1:0]};
		repeat (6) @(posedge i_clk);
		i_resetn <= 1'b1;
		repeat (6) @(posedge i_clk);
		check({ctrl.soft_shutdown_bit, ctrl.play_mode, ctrl.audio_modulation_bit}, 4'h8);
		check(ctrl.channel_enable, 16'hffff);
		check({ctrl.cascade_role_bit, ctrl.current_scale, ctrl.auto_gain_off_bit, ctrl.audio_gain_field}, 8'h00);
		check({ctrl.channel_function, port_drive.out_enable}, 16'h0000);
		check(port_drive.out_level, 8'h00);
		check({ctrl.sample_rate, ctrl.first_frame}, 16'h0000);
		check({irq_line, sda_line}, 2'h3);
		for (int m = 0; m < 4; m++) begin
			v = 8'($urandom);
			v[6:5] = 2'(m);
			v[7] = ~v[7];
			q = {v};
			wr(8'h00);
			check({ctrl.soft_shutdown_bit, ctrl.play_mode, ctrl.audio_modulation_bit, 4'h0}, exp_mode(v));
		end
		q = {};
		for (int k = 1; k < 8; k++) begin
			regs[k] = 8'($urandom);
			q.push_back(regs[k]);
		end
		wr(8'h01);
		check(ctrl.channel_enable, {regs[1], regs[2]});
		check({ctrl.cascade_role_bit, ctrl.current_scale, ctrl.auto_gain_off_bit, ctrl.audio_gain_field}, regs[3]);
		check(ctrl.channel_function, regs[4]);
		check(port_drive.out_enable, exp_oe(regs[4], regs[5]));
		check(port_drive.out_level, regs[6]);
		q = {8'($urandom)};
		wr(8'h09);
		check(ctrl.sample_rate, q[0]);
		v = q[0];
		q = {~v};
		u_ldc_bus_master.write_regs({`LDC_BUS_ADDR_FIXED, ~dev[1:0]}, 8'h09, q, ack);
		check(ack, 1'b0);
		check(ctrl.sample_rate, v);
		q = {8'($urandom), 8'($urandom)};
		wr(8'hb6);
		check({ctrl.frame_interval, ctrl.first_frame}, {q[0], q[1]});
		// Pending duties must not reach the active set before the trigger
		q = {};
		for (int k = 0; k < 16; k++) begin
			duty[k] = 8'($urandom) | 8'h01;
			q.push_back(duty[k]);
		end
		wr(8'h10);
		for (int k = 0; k < 16; k++) begin
			check(duty_act[k], 8'h00);
		end
		q = {8'($urandom)};
		wr(8'hb0);
		for (int k = 0; k < 16; k++) begin
			check(duty_act[k], duty[k]);
		end
		q = {};
		frm[144] = 8'h00;
		for (int k = 0; k < 144; k++) begin
			frm[k] = 8'($urandom);
			q.push_back(frm[k]);
		end
		wr(8'h20);
		for (int k = 0; k < 145; k++) begin
			frame_idx <= 8'(k);
			repeat (2) @(posedge i_clk);
			check(frame_data, frm[k]);
		end
		// Upper channels as inputs, channel 8 masked, the rest enabled
		q = {8'hff, 8'hff, 8'h00, 8'h01};
		wr(8'h04);
		check(port_drive.out_enable, 8'h00);
		u_ldc_bus_master.read_reg(dev, 8'h08, r);
		pins <= 8'h01;
		repeat (12) @(posedge i_clk);
		check(irq_line, 1'b1);
		v = 8'($urandom) | 8'h03;
		pins <= v;
		repeat (12) @(posedge i_clk);
		check(irq_line, 1'b0);
		u_ldc_bus_master.read_reg(dev, 8'h08, r);
		check(r, v);
		check(irq_line, 1'b1);
		u_ldc_bus_master.read_reg(dev, 8'h00, r);
		check(r, 8'h00);
		wrap_up();
	end
endmodule
